/* File: shared/sarf_params.svh */
/*
  Timing counts and frame layout of the serial converter readout.
  Assumes a 125 MHz system clock; included by bare name.
*/
`ifndef SARF_PARAMS_SVH
`define SARF_PARAMS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SARF_RESULT_BITS 12
`define SARF_LEAD_ZEROS 4
`define SARF_RISE_TRACK 5'h0d
`define SARF_FALL_RELEASE 5'h10

// ----------------------------------------
// Timing
// ----------------------------------------
`define SARF_CLK_MHZ 125
`define SARF_POWER_UP_NS 1000
`define SARF_POWER_UP_CYC ((`SARF_POWER_UP_NS * `SARF_CLK_MHZ + 999) / 1000)

`endif

/* File: shared/sarf_pkg.sv */
/*
  Types of the serial converter readout.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package sarf_pkg;

  typedef enum logic [0:0] {
    SARF_IDLE,
    SARF_CONV
  } sarf_state_t;

endpackage

`default_nettype wire

/* File: rtl/sarf_edge_det.sv */
/*
  Edge detector for an input already synchronous to the clock.
  Assumes the input is registered upstream or sampled cleanly.
*/
`timescale 1ns/1ps
`default_nettype none

module sarf_edge_det (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Level in
  input wire logic i_level,
  // Edge pulses out
  output logic o_rise,
  output logic o_fall
);

  logic prev_q;
  logic prev_d;

  always_comb
  begin
    prev_d = i_level;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      prev_q <= 1'b1;
    else
      prev_q <= prev_d;
  end

  assign o_rise = i_level & ~prev_q;
  assign o_fall = ~i_level & prev_q;

endmodule

`default_nettype wire

/* File: rtl/sarf_frame.sv */
/*
  Conversion and readout frame of a 12-bit serial converter.
  Assumes frame select and serial clock are synchronous to i_clk and
  that the converter core presents its code on i_sample_code.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sarf_params.svh"

module sarf_frame #(
  parameter int RESULT_BITS = `SARF_RESULT_BITS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Host link
  input wire logic i_frame_sel_n,
  input wire logic i_sclk,
  output logic o_serial_result_out,
  output logic o_serial_result_oe,
  // Converter core
  input wire logic [RESULT_BITS-1:0] i_sample_code,
  input wire logic i_power_down,
  output logic o_hold,
  output logic o_acquisition_window,
  output logic o_ready,
  output logic o_frame_suspect
);

  localparam int SHIFT_BITS = RESULT_BITS + `SARF_LEAD_ZEROS;

  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;

  sarf_edge_det u_cs_edge (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_level(i_frame_sel_n),
    .o_rise(cs_rise),
    .o_fall(cs_fall)
  );

  sarf_edge_det u_sclk_edge (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_level(i_sclk),
    .o_rise(sclk_rise),
    .o_fall(sclk_fall)
  );

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  sarf_pkg::sarf_state_t state_q, state_d;
  logic [4:0] rise_cnt_q, rise_cnt_d;
  logic [4:0] fall_cnt_q, fall_cnt_d;
  logic [SHIFT_BITS-1:0] shift_q, shift_d;
  logic [RESULT_BITS-1:0] code_q, code_d;
  logic hold_q, hold_d;
  logic oe_q, oe_d;
  logic acq_q, acq_d;
  logic suspect_q, suspect_d;
  // Warm-up status, read at the sample instant
  logic ready_q, ready_d;

  always_comb
  begin
    state_d = state_q;
    rise_cnt_d = rise_cnt_q;
    fall_cnt_d = fall_cnt_q;
    shift_d = shift_q;
    code_d = code_q;
    hold_d = hold_q;
    oe_d = oe_q;
    acq_d = 1'b0;
    suspect_d = suspect_q;
    if (cs_fall)
    begin
      // Sample instant: capture code, hold, drive the line
      state_d = sarf_pkg::SARF_CONV;
      code_d = i_sample_code;
      shift_d = {{`SARF_LEAD_ZEROS{1'b0}}, i_sample_code};
      hold_d = 1'b1;
      oe_d = 1'b1;
      rise_cnt_d = 5'h00;
      fall_cnt_d = 5'h00;
      suspect_d = ~ready_q;
    end
    else if (cs_rise)
    begin
      // Early end of frame; the core goes back to tracking
      state_d = sarf_pkg::SARF_IDLE;
      oe_d = 1'b0;
      hold_d = 1'b0;
    end
    else
    begin
      unique case (state_q)
        sarf_pkg::SARF_IDLE:
        begin
          oe_d = 1'b0;
        end
        sarf_pkg::SARF_CONV:
        begin
          if (sclk_rise && rise_cnt_q < `SARF_RISE_TRACK)
          begin
            rise_cnt_d = rise_cnt_q + 5'h01;
            if (rise_cnt_d == `SARF_RISE_TRACK)
            begin
              hold_d = 1'b0;
              acq_d = 1'b1;
            end
          end
          if (sclk_fall)
          begin
            fall_cnt_d = fall_cnt_q + 5'h01;
            shift_d = {shift_q[SHIFT_BITS-2:0], 1'b0};
            if (fall_cnt_d == `SARF_FALL_RELEASE)
            begin
              oe_d = 1'b0;
              state_d = sarf_pkg::SARF_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= sarf_pkg::SARF_IDLE;
      rise_cnt_q <= 5'h00;
      fall_cnt_q <= 5'h00;
      shift_q <= '0;
      code_q <= '0;
      hold_q <= 1'b0;
      oe_q <= 1'b0;
      acq_q <= 1'b0;
      suspect_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      rise_cnt_q <= rise_cnt_d;
      fall_cnt_q <= fall_cnt_d;
      shift_q <= shift_d;
      code_q <= code_d;
      hold_q <= hold_d;
      oe_q <= oe_d;
      acq_q <= acq_d;
      suspect_q <= suspect_d;
    end
  end

  // ----------------------------------------
  // Warm-up after power-down
  // ----------------------------------------
  // Results converted before the count expires are flagged, not blocked
  localparam logic [7:0] WARM_CYC = 8'(`SARF_POWER_UP_CYC);
  logic [7:0] warm_cnt_q, warm_cnt_d;

  always_comb
  begin
    warm_cnt_d = warm_cnt_q;
    ready_d = ready_q;
    if (i_power_down)
    begin
      warm_cnt_d = WARM_CYC;
      ready_d = 1'b0;
    end
    else if (warm_cnt_q != 8'h00)
    begin
      warm_cnt_d = warm_cnt_q - 8'h01;
      ready_d = 1'b0;
    end
    else
    begin
      ready_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      warm_cnt_q <= 8'h00;
      ready_q <= 1'b0;
    end
    else
    begin
      warm_cnt_q <= warm_cnt_d;
      ready_q <= ready_d;
    end
  end

  assign o_serial_result_out = shift_q[SHIFT_BITS-1];
  assign o_serial_result_oe = oe_q;
  assign o_hold = hold_q;
  assign o_acquisition_window = acq_q;
  assign o_ready = ready_q;
  assign o_frame_suspect = suspect_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sample_hold_a: assert property (cs_fall |=> o_hold && code_q == $past(i_sample_code))
    else $error("hold not entered at frame start");
  track_return_a: assert property (
    state_q == sarf_pkg::SARF_CONV && !cs_fall && !cs_rise && sclk_rise && rise_cnt_q == `SARF_RISE_TRACK - 5'h01
    |=> !o_hold && o_acquisition_window)
    else $error("track not resumed on 13th rise");
  end_release_a: assert property (
    state_q == sarf_pkg::SARF_CONV && !cs_fall && !cs_rise && sclk_fall && fall_cnt_q == `SARF_FALL_RELEASE - 5'h01
    |=> !o_serial_result_oe)
    else $error("output not released on 16th fall");
  warm_up_a: assert property ($rose(i_power_down) ##1 $fell(i_power_down) |-> !o_ready [*8])
    else $error("ready too soon after power-down");
  msb_first_a: assert property (
    state_q == sarf_pkg::SARF_CONV && !cs_fall && !cs_rise && sclk_fall && fall_cnt_q == 5'(`SARF_LEAD_ZEROS - 1)
    |=> o_serial_result_out == code_q[RESULT_BITS-1])
    else $error("msb not after leading zeros");
  lead_zero_a: assert property (cs_fall |=> !o_serial_result_out ##0 o_serial_result_oe)
    else $error("frame does not open with zero");
  shift_edge_a: assert property (
    $changed(o_serial_result_out) && o_serial_result_oe |-> $past(sclk_fall || cs_fall))
    else $error("data moved off a falling edge");
  early_release_a: assert property (cs_rise |=> !o_serial_result_oe [*1])
    else $error("output held after frame select rise");

  sequence end_release_seq;
    sclk_fall && fall_cnt_q == `SARF_FALL_RELEASE - 5'h01 ##1 !o_serial_result_oe;
  endsequence

  full_frame_c: cover property (end_release_seq);
  early_end_c: cover property (o_serial_result_oe ##1 cs_rise);
  suspect_c: cover property (o_frame_suspect && o_hold);

endmodule

`default_nettype wire

/* File: tb/sarf_host.sv */
/*
  Host model: drives frame select and serial clock, captures result bits.
  Assumes it shares the device clock and drives only after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none

module sarf_host (
  // Clock
  input wire logic i_clk,
  // Link
  output logic o_frame_sel_n,
  output logic o_sclk,
  input wire logic i_sdo,
  // Capture
  output logic [15:0] o_word,
  output logic o_done,
  output logic [4:0] o_rises
);
  initial
  begin
    o_frame_sel_n = 1'b1;
    o_sclk = 1'b1;
    o_word = 16'h0;
    o_done = 1'b0;
    o_rises = 5'h0;
  end

  // --------------------------------
  // One frame, cut short when nfalls < 16
  // --------------------------------
  task automatic frame(input int half, input int nfalls);
    o_frame_sel_n <= 1'b0;
    o_rises <= 5'h0;
    o_word <= 16'h0;
    for (int k = 0; k < nfalls; k++)
    begin
      repeat (half) @(posedge i_clk);
      o_sclk <= 1'b0;
      o_word <= {o_word[14:0], i_sdo};
      repeat (half) @(posedge i_clk);
      o_sclk <= 1'b1;
      o_rises <= o_rises + 5'h1;
    end
    repeat (half) @(posedge i_clk);
    o_frame_sel_n <= 1'b1;
    o_done <= (nfalls == 16);
    @(posedge i_clk);
    o_done <= 1'b0;
    // Covers acquisition and quiet gap at 8 ns per cycle
    repeat (44) @(posedge i_clk);
  endtask
endmodule

`default_nettype wire

/* File: tb/tb_sarf_frame.sv */
/*
  Self-checking bench for the converter readout frame.
  Assumes the host model drives the link and captures the bits.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_sarf_frame;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pd = 1'b0;
  logic [11:0] code = 12'h0;
  logic fs_n, sclk, sdo, oe, hold, acq, ready, suspect, done;
  logic sdo_pin;
  logic [15:0] word;
  logic [4:0] rises;
  logic [2:0] fs_h = 3'h0;
  logic hold_p = 1'b0;
  logic [15:0] exp_q[$];
  int error_cnt = 0;
  int compares = 0;
  int acq_cnt = 0;
  int full_cnt = 0;
  int seed = 32'hbc30;

  always #4 clk = ~clk;

  sarf_frame u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_frame_sel_n(fs_n), .i_sclk(sclk),
    .o_serial_result_out(sdo), .o_serial_result_oe(oe), .i_sample_code(code), .i_power_down(pd),
    .o_hold(hold), .o_acquisition_window(acq), .o_ready(ready), .o_frame_suspect(suspect));

  // Released line shows the inverse of the serial output sdo, so a late capture shows up
  assign sdo_pin = oe ? sdo : ~sdo;

  sarf_host u_host (.i_clk(clk), .o_frame_sel_n(fs_n), .o_sclk(sclk), .i_sdo(sdo_pin),
    .o_word(word), .o_done(done), .o_rises(rises));

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t bit got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic run(input int half, input logic [11:0] c);
    code <= c;
    exp_q.push_back({4'h0, c});
    full_cnt++;
    @(posedge clk);
    u_host.frame(half, 16);
  endtask

  // --------------------------------
  // Output monitor
  // --------------------------------
  always @(posedge clk)
  begin
    fs_h <= {fs_h[1:0], fs_n};
    hold_p <= hold;
    if (hold && !hold_p)
    begin
      cmp_bit(oe, 1'b1);
      cmp_bit(sdo, 1'b0);
    end
    if (acq)
    begin
      acq_cnt++;
      cmp_word({11'h000, rises}, 16'h000d);
      cmp_bit(hold, 1'b0);
    end
    if (!fs_n && rises == 5'h10) cmp_bit(oe, 1'b0);
    if (fs_h == 3'h7) cmp_bit(oe, 1'b0);
    if (done)
    begin
      cmp_word(word, exp_q.pop_front());
      cmp_bit(hold, 1'b0);
    end
  end

  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (130) @(posedge clk);
    cmp_bit(ready, 1'b1);
    run(4, 12'hfff);
    run(5, 12'h000);
    for (int i = 0; i < 5; i++) run(4 + 2 * (i % 2), 12'($random(seed)));
    code <= 12'h5a5;
    u_host.frame(4, 8);
    run(4, 12'($random(seed)));
    pd <= 1'b1;
    repeat (3) @(posedge clk);
    cmp_bit(ready, 1'b0);
    pd <= 1'b0;
    repeat (120) @(posedge clk);
    cmp_bit(ready, 1'b0);
    repeat (10) @(posedge clk);
    cmp_bit(ready, 1'b1);
    // One-cycle power-down, then a frame inside the warm-up
    pd <= 1'b1;
    @(posedge clk);
    pd <= 1'b0;
    run(4, 12'($random(seed)));
    cmp_bit(suspect, 1'b1);
    run(4, 12'ha5c);
    cmp_bit(suspect, 1'b0);
    cmp_word(16'(acq_cnt), 16'(full_cnt));
    repeat (20) @(posedge clk);
    stop_test();
  end
endmodule

`default_nettype wire
